// ---- lds_pkg.sv ----
package lds_pkg;
  // register addresses on the special-function bus
  localparam logic [7:0] ADDR_IRQ_STATUS   = 8'hAE;
  localparam logic [7:0] ADDR_SCAN_RUN     = 8'hAF;
  localparam logic [7:0] ADDR_DISPLAY_CTRL = 8'hB1;
  localparam logic [7:0] ADDR_DISPLAY_MODE = 8'hB2;
  localparam logic [7:0] ADDR_FIRST_ON     = 8'hB3;
  localparam logic [7:0] ADDR_SECOND_ON    = 8'hB4;
  localparam logic [7:0] ADDR_IRQ_ENABLE   = 8'hE6;
  localparam logic [7:0] ADDR_IRQ_FLAG     = 8'hF1;
  localparam logic [7:0] ADDR_IRQ_PRIORITY = 8'hF6;
  // register addresses on the secondary bus
  localparam logic [7:0] ADDR_LAMP_CURRENT = 8'h31;
  localparam logic [7:0] ADDR_START_PAD    = 8'h58;

  // field positions
  localparam int LED_STATUS_BIT   = 0;
  localparam int SCAN_RUN_BIT     = 0;
  localparam int SCAN_MODE_BIT    = 1;
  localparam int LED_SELECT_BIT   = 2;
  localparam int SIZE_LSB         = 3;
  localparam int SIZE_UPPER_BIT   = 5;
  localparam int SERIAL_MODE_BIT  = 7;
  localparam int DISPLAY_IRQ_BIT  = 6;
  localparam int BANK_LOW_BITS    = 2;

  // reset values and read masks
  localparam logic [7:0] REG_RESET         = 8'h00;
  localparam logic [7:0] BANK_MASK         = 8'hFC;
  localparam logic [7:0] CURRENT_MASK      = 8'h0F;
  localparam logic [7:0] START_MASK        = 8'h07;

  // timing: one on-time step
  localparam int STEP_TIME_NS  = 16_000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int STEP_CYCLES   = (STEP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // pad order: code 000 names pin 6, and the smallest matrix uses five ports
  localparam logic [2:0] PAD_CODE_OFFSET = 3'h6;
  localparam logic [3:0] BASE_PORTS      = 4'h5;

  typedef enum logic [1:0] {
    LDS_IDLE  = 2'b00,
    LDS_LIGHT = 2'b01,
    LDS_HOLD  = 2'b11
  } lds_state_type;
endpackage

// ---- lds_scan_if.sv ----
`timescale 1ns/10ps
interface lds_scan_if;
  logic       run;
  logic       tick;
  logic [2:0] start_code;
  logic       use_start;
  logic [2:0] position;
  logic [2:0] pad;

  modport ctrl  (output run, output start_code, output use_start, output position,
                 input tick, input pad);
  modport timer (input run, output tick);
  modport order (input start_code, input use_start, input position, output pad);
endinterface

// ---- lds_step_timer.sv ----
`timescale 1ns/10ps
module lds_step_timer
  import lds_pkg::*;
#(
  parameter int STEPS = STEP_CYCLES
)(
  input  wire logic   sys_clk_i,
  input  wire logic   rst_n_i,
  lds_scan_if.timer   scan
);
  logic [12:0] div_ff;
  logic [12:0] nxt_div;
  logic        tick_ff;
  wire         wrap = (div_ff == 13'(STEPS - 1));

  // a 13-bit prescaler with a one-cycle tick cannot serve other counts
  if (STEPS < 2 || STEPS > 8191)
  begin : g_bad_steps
    $error("step count out of range");
  end

  // prescaler restarts whenever the scan stops, so each group starts aligned
  assign nxt_div  = (!scan.run || wrap) ? 13'h0000 : div_ff + 13'h0001;
  assign scan.tick = tick_ff;

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      div_ff  <= 13'h0000;
      tick_ff <= 1'b0;
    end
    else
    begin
      div_ff  <= nxt_div;
      tick_ff <= scan.run && wrap;
    end
  end

  a_tick_spacing: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    tick_ff |=> !tick_ff) else $error("step tick lasted two cycles");
endmodule

// ---- lds_pad_order.sv ----
`timescale 1ns/10ps
module lds_pad_order
  import lds_pkg::*;
(
  lds_scan_if.order scan
);
  // pin number of the chosen start code, wrapping through pins 6,7,0..5
  function automatic logic [2:0] code_to_pin(input logic [2:0] code);
    code_to_pin = code + PAD_CODE_OFFSET;
  endfunction

  wire [2:0] start_pin = scan.use_start ? code_to_pin(scan.start_code)
                                        : code_to_pin(3'h0);

  // modulo-8 sum keeps the order cyclic from the start pad
  assign scan.pad = start_pin + scan.position;
endmodule

// ---- lds_scan_core.sv ----
`timescale 1ns/10ps
// Behaviour
// - first segment lasts (first on-time + 1) steps of 16 us
// - second segment lasts (second on-time + 1) steps of 16 us
// - group time follows second on-time when first is shorter
// - group time follows first on-time when first is longer
// - second on-time acts only in serial dot-matrix mode
// - LED status bit 0 stays set until software writes 0
// - any write to the scan-run register clears the LED status
// - shared display interrupt leaves only when enable bit 6 is 1
// - flag bit 6 holds pending display interrupt, writing 0 clears it
// - priority bit 6 high marks the display interrupt high priority
// - 3-bit code picks start pin 6,7,0..5, scan wraps cyclically
// - start pad applies only in serial mode with upper size bit 0
// - 4-bit drive field selects one of sixteen rising lamp currents
// - segment-select bit 0 lights lamp in first segment, 1 in second
// - scanning runs while scan-run bit 0 and LED-select bit 2 are both 1, resets to 0
module lds_scan_core
  import lds_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  input  wire logic [7:0] sec_addr_i,
  input  wire logic       sec_wr_i,
  input  wire logic       sec_rd_i,
  input  wire logic [7:0] sec_wdata_i,
  output logic      [7:0] sec_rdata_o,
  input  wire logic       lamp_on_i,
  input  wire logic       lamp_segment_select_i,
  output logic            lamp_light_o,
  output logic      [2:0] scan_pad_o,
  output logic            scan_active_o,
  output logic      [3:0] lamp_drive_o,
  output logic            irq_o,
  output logic            irq_high_prio_o
);
  lds_scan_if scan ();

  lds_step_timer #(
    .STEPS (STEP_CYCLES)
  ) u_timer (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .scan      (scan)
  );

  lds_pad_order u_order (
    .scan (scan)
  );

  // register state
  logic [7:0]    status_ff;
  logic          scan_run_ff;
  logic [7:0]    ctrl_ff;
  logic [7:0]    mode_ff;
  logic [7:0]    first_on_ff;
  logic [7:0]    second_on_ff;
  logic [7:0]    irq_enable_ff;
  logic [7:0]    irq_flag_ff;
  logic [7:0]    irq_prio_ff;
  logic [3:0]    current_ff;
  logic [2:0]    start_code_ff;
  // scan state
  lds_state_type state_ff;
  lds_state_type nxt_state;
  logic [7:0]    step_cnt_ff;
  logic [7:0]    nxt_step_cnt;
  logic [2:0]    position_ff;
  logic [2:0]    nxt_position;

  // address decode
  wire sfr_wr_status = sfr_wr_i && (sfr_addr_i == ADDR_IRQ_STATUS);
  wire sfr_wr_run    = sfr_wr_i && (sfr_addr_i == ADDR_SCAN_RUN);
  wire sfr_wr_ctrl   = sfr_wr_i && (sfr_addr_i == ADDR_DISPLAY_CTRL);
  wire sfr_wr_mode   = sfr_wr_i && (sfr_addr_i == ADDR_DISPLAY_MODE);
  wire sfr_wr_first  = sfr_wr_i && (sfr_addr_i == ADDR_FIRST_ON);
  wire sfr_wr_second = sfr_wr_i && (sfr_addr_i == ADDR_SECOND_ON);
  wire sfr_wr_enable = sfr_wr_i && (sfr_addr_i == ADDR_IRQ_ENABLE);
  wire sfr_wr_flag   = sfr_wr_i && (sfr_addr_i == ADDR_IRQ_FLAG);
  wire sfr_wr_prio   = sfr_wr_i && (sfr_addr_i == ADDR_IRQ_PRIORITY);
  wire sec_wr_drive  = sec_wr_i && (sec_addr_i == ADDR_LAMP_CURRENT);
  wire sec_wr_start  = sec_wr_i && (sec_addr_i == ADDR_START_PAD);

  // mode decode
  wire serial_mode  = mode_ff[SERIAL_MODE_BIT];
  wire led_selected = ctrl_ff[LED_SELECT_BIT];
  wire hold_mode    = !ctrl_ff[SCAN_MODE_BIT];
  wire [1:0] size_code = ctrl_ff[SIZE_LSB +: 2];
  wire size_upper   = ctrl_ff[SIZE_UPPER_BIT];
  wire run_enable   = scan_run_ff && led_selected;

  // second on-time is ignored outside serial dot-matrix mode
  wire [7:0] second_eff = serial_mode ? second_on_ff : 8'h00;
  // group length is the longer of the two segments
  wire [7:0] group_last = (serial_mode && (first_on_ff < second_on_ff))
                          ? second_on_ff
                          : first_on_ff;
  wire [2:0] last_port  = 3'(BASE_PORTS + 4'(size_code) - 4'h1);

  // segment windows, counted in 16 us steps from the group start
  wire seg1_on   = (state_ff == LDS_LIGHT) && (step_cnt_ff <= first_on_ff);
  wire seg2_on   = (state_ff == LDS_LIGHT) && serial_mode
                   && (step_cnt_ff <= second_eff);
  wire group_end = (state_ff == LDS_LIGHT) && scan.tick && (step_cnt_ff == group_last);
  wire round_end = group_end && (position_ff == last_port);
  wire scan_event = round_end;

  // interface drive
  assign scan.run        = (state_ff == LDS_LIGHT);
  assign scan.start_code = start_code_ff;
  assign scan.use_start  = serial_mode && !size_upper;
  assign scan.position   = position_ff;

  // lamp lights in the segment that its select bit names
  wire lamp_light = lamp_on_i && (lamp_segment_select_i ? seg2_on : seg1_on);

  // scan sequencer: interrupt mode holds after each round until status is cleared
  always_comb
  begin
    nxt_state    = state_ff;
    nxt_step_cnt = step_cnt_ff;
    nxt_position = position_ff;
    case (state_ff)
      LDS_IDLE:
      begin
        nxt_step_cnt = 8'h00;
        nxt_position = 3'h0;
        if (run_enable)
          nxt_state = LDS_LIGHT;
      end
      LDS_LIGHT:
      begin
        if (!run_enable)
          nxt_state = LDS_IDLE;
        else if (group_end)
        begin
          nxt_step_cnt = 8'h00;
          nxt_position = round_end ? 3'h0 : position_ff + 3'h1;
          if (round_end && hold_mode)
            nxt_state = LDS_HOLD;
        end
        else if (scan.tick)
          nxt_step_cnt = step_cnt_ff + 8'h01;
      end
      LDS_HOLD:
      begin
        if (!run_enable)
          nxt_state = LDS_IDLE;
        else if (!status_ff[LED_STATUS_BIT])
          nxt_state = LDS_LIGHT;
      end
      default:
        nxt_state = LDS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_ff    <= LDS_IDLE;
      step_cnt_ff <= 8'h00;
      position_ff <= 3'h0;
    end
    else
    begin
      state_ff    <= nxt_state;
      step_cnt_ff <= nxt_step_cnt;
      position_ff <= nxt_position;
    end
  end

  // next values of the event-driven bits; a set in the clearing cycle wins
  wire nxt_led_status = scan_event
                        || (status_ff[LED_STATUS_BIT]
                            && !(sfr_wr_status && !sfr_wdata_i[LED_STATUS_BIT])
                            && !sfr_wr_run);
  wire nxt_disp_flag  = scan_event
                        || (sfr_wr_flag ? sfr_wdata_i[DISPLAY_IRQ_BIT]
                                        : irq_flag_ff[DISPLAY_IRQ_BIT]);

  // plain control registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      scan_run_ff   <= 1'b0;
      ctrl_ff       <= REG_RESET;
      mode_ff       <= REG_RESET;
      first_on_ff   <= REG_RESET;
      second_on_ff  <= REG_RESET;
      irq_enable_ff <= REG_RESET;
      irq_prio_ff   <= REG_RESET;
      current_ff    <= 4'h0;
      start_code_ff <= 3'h0;
    end
    else
    begin
      if (sfr_wr_run)
        scan_run_ff <= sfr_wdata_i[SCAN_RUN_BIT];
      if (sfr_wr_ctrl)
        ctrl_ff <= sfr_wdata_i & 8'h7F;
      if (sfr_wr_mode)
        mode_ff <= sfr_wdata_i;
      if (sfr_wr_first)
        first_on_ff <= sfr_wdata_i;
      if (sfr_wr_second)
        second_on_ff <= sfr_wdata_i;
      if (sfr_wr_enable)
        irq_enable_ff <= sfr_wdata_i & BANK_MASK;
      if (sfr_wr_prio)
        irq_prio_ff <= sfr_wdata_i & BANK_MASK;
      if (sec_wr_drive)
        current_ff <= sec_wdata_i[3:0];
      if (sec_wr_start)
        start_code_ff <= sec_wdata_i[2:0];
    end
  end

  // status and flag banks; only the display bits are set by this block
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      status_ff   <= REG_RESET;
      irq_flag_ff <= REG_RESET;
    end
    else
    begin
      status_ff[LED_STATUS_BIT]    <= nxt_led_status;
      irq_flag_ff[DISPLAY_IRQ_BIT] <= nxt_disp_flag;
    end
  end

  // read mux; unmapped addresses read zero, reserved bits read zero
  logic [7:0] sfr_read;
  logic [7:0] sec_read;
  always_comb
  begin
    case (sfr_addr_i)
      ADDR_IRQ_STATUS:   sfr_read = status_ff;
      ADDR_SCAN_RUN:     sfr_read = {7'h00, scan_run_ff};
      ADDR_DISPLAY_CTRL: sfr_read = ctrl_ff;
      ADDR_DISPLAY_MODE: sfr_read = mode_ff;
      ADDR_FIRST_ON:     sfr_read = first_on_ff;
      ADDR_SECOND_ON:    sfr_read = second_on_ff;
      ADDR_IRQ_ENABLE:   sfr_read = irq_enable_ff;
      ADDR_IRQ_FLAG:     sfr_read = irq_flag_ff;
      ADDR_IRQ_PRIORITY: sfr_read = irq_prio_ff;
      default:           sfr_read = 8'h00;
    endcase
    case (sec_addr_i)
      ADDR_LAMP_CURRENT: sec_read = {4'h0, current_ff} & CURRENT_MASK;
      ADDR_START_PAD:    sec_read = {5'h00, start_code_ff} & START_MASK;
      default:           sec_read = 8'h00;
    endcase
  end

  // registered outputs; read data lands one cycle after the strobe
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sfr_rdata_o     <= 8'h00;
      sec_rdata_o     <= 8'h00;
      lamp_light_o    <= 1'b0;
      scan_pad_o      <= 3'h0;
      scan_active_o   <= 1'b0;
      lamp_drive_o    <= 4'h0;
      irq_o           <= 1'b0;
      irq_high_prio_o <= 1'b0;
    end
    else
    begin
      if (sfr_rd_i)
        sfr_rdata_o <= sfr_read;
      if (sec_rd_i)
        sec_rdata_o <= sec_read;
      lamp_light_o    <= lamp_light;
      scan_pad_o      <= scan.pad;
      scan_active_o   <= (state_ff == LDS_LIGHT);
      lamp_drive_o    <= current_ff;
      irq_o           <= irq_flag_ff[DISPLAY_IRQ_BIT]
                         && irq_enable_ff[DISPLAY_IRQ_BIT];
      irq_high_prio_o <= irq_prio_ff[DISPLAY_IRQ_BIT];
    end
  end

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_round_done;
    scan_event ##1 status_ff[LED_STATUS_BIT];
  endsequence
  sequence s_software_clear;
    sfr_wr_status && !sfr_wdata_i[LED_STATUS_BIT] && !scan_event;
  endsequence

  a_event_sets_both: assert property (
    s_round_done |-> irq_flag_ff[DISPLAY_IRQ_BIT])
    else $error("status and flag not set together");
  a_status_zero_clear: assert property (
    s_software_clear |=> !status_ff[LED_STATUS_BIT])
    else $error("status bit survived a write of zero");
  a_status_run_clear: assert property (
    sfr_wr_run && !scan_event |=> !status_ff[LED_STATUS_BIT])
    else $error("status bit survived a scan-run write");
  a_status_sticky: assert property (
    status_ff[LED_STATUS_BIT] && !sfr_wr_status && !sfr_wr_run |=> status_ff[LED_STATUS_BIT])
    else $error("status bit dropped without a clear");
  a_irq_gated: assert property (
    irq_o |-> $past(irq_enable_ff[DISPLAY_IRQ_BIT]) && $past(irq_flag_ff[DISPLAY_IRQ_BIT]))
    else $error("interrupt left while disabled");
  a_flag_write_zero: assert property (
    sfr_wr_flag && !sfr_wdata_i[DISPLAY_IRQ_BIT] && !scan_event ##1 1 |=> !irq_o)
    else $error("flag clear did not reach interrupt");
  a_prio_follows: assert property (
    sfr_wr_prio ##1 1 |=> irq_high_prio_o == $past(sfr_wdata_i[DISPLAY_IRQ_BIT], 2))
    else $error("priority output disagrees with register");
  a_stop_idles: assert property (
    sfr_wr_run && !sfr_wdata_i[SCAN_RUN_BIT] ##1 1 |=> state_ff == LDS_IDLE ##1 !scan_active_o)
    else $error("scan kept running after stop");
  a_seg2_serial_only: assert property (
    !serial_mode |-> !seg2_on && group_last == first_on_ff)
    else $error("second on-time used outside serial mode");
  a_group_longest: assert property (
    group_end |-> step_cnt_ff >= first_on_ff && step_cnt_ff >= second_eff)
    else $error("group ended before the longer segment");
  a_seg1_closes: assert property (
    state_ff == LDS_LIGHT && scan.tick && step_cnt_ff == first_on_ff && !group_end
    |=> !seg1_on || state_ff != LDS_LIGHT)
    else $error("first segment overran its on-time");
  a_pad_start: assert property (
    scan.use_start && position_ff == 3'h0 |-> scan.pad == 3'(start_code_ff + PAD_CODE_OFFSET))
    else $error("scan did not start on the selected pad");
  a_pad_advance: assert property (
    group_end && !round_end && !sec_wr_start && !sfr_wr_ctrl && !sfr_wr_mode
    |=> scan.pad == 3'($past(scan.pad) + 3'h1))
    else $error("scan did not move to the next pad");
endmodule

// ---- lds_scan_core_tb_top.sv ----
`timescale 1ns/10ps
module lds_scan_core_tb_top;
  import lds_pkg::*;

  localparam int TIMEOUT = 80000;

  // address and all-ones readback of seven registers, indices 5 and 6 on the secondary bus
  function automatic logic [15:0] reg_entry(input int i);
    case (i)
      0:       reg_entry = {ADDR_FIRST_ON, 8'hFF};
      1:       reg_entry = {ADDR_SECOND_ON, 8'hFF};
      2:       reg_entry = {ADDR_IRQ_ENABLE, BANK_MASK};
      3:       reg_entry = {ADDR_IRQ_FLAG, 8'h40};
      4:       reg_entry = {ADDR_IRQ_PRIORITY, BANK_MASK};
      5:       reg_entry = {ADDR_LAMP_CURRENT, CURRENT_MASK};
      default: reg_entry = {ADDR_START_PAD, START_MASK};
    endcase
  endfunction

  logic       sys_clk_i;
  logic       rst_n_i;
  logic [7:0] sfr_addr_i;
  logic       sfr_wr_i;
  logic       sfr_rd_i;
  logic [7:0] sfr_wdata_i;
  logic [7:0] sfr_rdata_o;
  logic [7:0] sec_addr_i;
  logic       sec_wr_i;
  logic       sec_rd_i;
  logic [7:0] sec_wdata_i;
  logic [7:0] sec_rdata_o;
  logic       lamp_on_i;
  logic       lamp_segment_select_i;
  logic       lamp_light_o;
  logic [2:0] scan_pad_o;
  logic       scan_active_o;
  logic [3:0] lamp_drive_o;
  logic       irq_o;
  logic       irq_high_prio_o;
  int         fails = 0;
  int         check_count = 0;
  int         cycles = 0;
  int         n;

  lds_scan_core dut (
    .sys_clk_i             (sys_clk_i),
    .rst_n_i               (rst_n_i),
    .sfr_addr_i            (sfr_addr_i),
    .sfr_wr_i              (sfr_wr_i),
    .sfr_rd_i              (sfr_rd_i),
    .sfr_wdata_i           (sfr_wdata_i),
    .sfr_rdata_o           (sfr_rdata_o),
    .sec_addr_i            (sec_addr_i),
    .sec_wr_i              (sec_wr_i),
    .sec_rd_i              (sec_rd_i),
    .sec_wdata_i           (sec_wdata_i),
    .sec_rdata_o           (sec_rdata_o),
    .lamp_on_i             (lamp_on_i),
    .lamp_segment_select_i (lamp_segment_select_i),
    .lamp_light_o          (lamp_light_o),
    .scan_pad_o            (scan_pad_o),
    .scan_active_o         (scan_active_o),
    .lamp_drive_o          (lamp_drive_o),
    .irq_o                 (irq_o),
    .irq_high_prio_o       (irq_high_prio_o)
  );

  // 200 mhz system clock
  always #2.5 sys_clk_i = ~sys_clk_i;

  // hang guard, well above the longest scan wait
  always @(posedge sys_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == TIMEOUT)
    begin
      fails++;
      summarize;
    end
  end

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one write: strobe for a single cycle, both buses share address and data
  task automatic wr(input bit sec, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    sfr_addr_i  <= a;
    sec_addr_i  <= a;
    sfr_wdata_i <= d;
    sec_wdata_i <= d;
    sfr_wr_i    <= !sec;
    sec_wr_i    <= sec;
    @(posedge sys_clk_i);
    sfr_wr_i    <= 1'b0;
    sec_wr_i    <= 1'b0;
  endtask

  // read and compare; data is registered one cycle after the strobe edge
  task automatic rc(input bit sec, input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    @(posedge sys_clk_i);
    sfr_addr_i <= a;
    sec_addr_i <= a;
    sfr_rd_i   <= !sec;
    sec_rd_i   <= sec;
    @(posedge sys_clk_i);
    sfr_rd_i   <= 1'b0;
    sec_rd_i   <= 1'b0;
    #1;
    d = sec ? sec_rdata_o : sfr_rdata_o;
    chk({8'h00, d}, {8'h00, exp});
  endtask

  // outputs are registered behind the registers, so allow two edges
  task automatic settle;
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic wait_pad(output int cnt);
    logic [2:0] p;
    p = scan_pad_o;
    cnt = 0;
    while (scan_pad_o === p && cnt < 20000)
    begin
      @(posedge sys_clk_i);
      #1;
      cnt++;
    end
  endtask

  // stop, reprogram, restart and check the first pad
  task automatic cfg(input logic [7:0] md, input logic [7:0] ct, input logic [7:0] f,
                     input logic [7:0] s, input logic [2:0] code, input logic [2:0] pad);
    wr(0, ADDR_SCAN_RUN, 8'h00);
    settle;
    chk(16'(scan_active_o), 16'h0000);
    wr(0, ADDR_DISPLAY_MODE, md);
    wr(0, ADDR_DISPLAY_CTRL, ct);
    wr(0, ADDR_FIRST_ON, f);
    wr(0, ADDR_SECOND_ON, s);
    wr(1, ADDR_START_PAD, {5'h00, code});
    wr(0, ADDR_SCAN_RUN, 8'h01);
    settle;
    chk(16'(scan_active_o), 16'h0001);
    chk(16'(scan_pad_o), 16'(pad));
  endtask

  task automatic t_regs;
    logic [15:0] e;
    rc(0, ADDR_IRQ_STATUS, REG_RESET);
    wr(0, 8'h10, 8'hFF);
    rc(0, 8'h10, 8'h00);
    rc(1, 8'h10, 8'h00);
    // reset value, then all ones to expose reserved bits
    for (int i = 0; i < 7; i++)
    begin
      e = reg_entry(i);
      rc(i > 4, e[15:8], REG_RESET);
      wr(i > 4, e[15:8], 8'hFF);
      rc(i > 4, e[15:8], e[7:0]);
    end
    settle;
    chk(16'(irq_o), 16'h0001);
    chk(16'(irq_high_prio_o), 16'h0001);
    for (int i = 0; i < 7; i++)
    begin
      e = reg_entry(i);
      wr(i > 4, e[15:8], 8'h00);
      rc(i > 4, e[15:8], 8'h00);
    end
  endtask

  task automatic t_drive;
    for (int c = 0; c < 16; c++)
    begin
      wr(1, ADDR_LAMP_CURRENT, {4'hA, 4'(c)});
      settle;
      chk(16'(lamp_drive_o), 16'(c));
    end
    // leave a low code so the lamps scanned later stay under their rating
    wr(1, ADDR_LAMP_CURRENT, 8'h02);
    settle;
    chk(16'(lamp_drive_o), 16'h0002);
  endtask

  task automatic t_irq;
    wr(0, ADDR_IRQ_FLAG, 8'h40);
    settle;
    chk(16'(irq_o), 16'h0000);
    wr(0, ADDR_IRQ_ENABLE, 8'h40);
    settle;
    chk(16'(irq_o), 16'h0001);
    wr(0, ADDR_IRQ_FLAG, 8'h00);
    settle;
    chk(16'(irq_o), 16'h0000);
    rc(0, ADDR_IRQ_FLAG, 8'h00);
    wr(0, ADDR_IRQ_PRIORITY, 8'h40);
    settle;
    chk(16'(irq_high_prio_o), 16'h0001);
    wr(0, ADDR_IRQ_PRIORITY, 8'hBF);
    settle;
    chk(16'(irq_high_prio_o), 16'h0000);
  endtask

  // serial mode, first segment longer, start code 7, one full round
  task automatic t_scan1;
    cfg(8'h80, 8'h06, 8'h01, 8'h00, 3'h7, 3'h5);
    wait_pad(n);
    chk(16'(scan_pad_o), 16'h0006);
    wait_pad(n);
    chk(16'(n), 16'(2 * STEP_CYCLES));
    chk(16'(scan_pad_o), 16'h0007);
    @(posedge sys_clk_i);
    lamp_on_i             <= 1'b1;
    lamp_segment_select_i <= 1'b1;
    settle;
    chk(16'(lamp_light_o), 16'h0001);
    // past the one-step second window, inside the two-step first one
    repeat (STEP_CYCLES + 800) @(posedge sys_clk_i);
    #1;
    chk(16'(lamp_light_o), 16'h0000);
    @(posedge sys_clk_i);
    lamp_segment_select_i <= 1'b0;
    settle;
    chk(16'(lamp_light_o), 16'h0001);
    @(posedge sys_clk_i);
    lamp_on_i <= 1'b0;
    settle;
    chk(16'(lamp_light_o), 16'h0000);
    wait_pad(n);
    wait_pad(n);
    chk(16'(scan_pad_o), 16'h0001);
    wait_pad(n);
    chk(16'(scan_pad_o), 16'h0005);
    repeat (4) @(posedge sys_clk_i);
    #1;
    chk(16'(irq_o), 16'h0001);
    rc(0, ADDR_IRQ_STATUS, 8'h01);
    rc(0, ADDR_IRQ_FLAG, 8'h40);
    wr(0, ADDR_SCAN_RUN, 8'h01);
    rc(0, ADDR_IRQ_STATUS, 8'h00);
    rc(0, ADDR_IRQ_FLAG, 8'h40);
    wr(0, ADDR_IRQ_FLAG, 8'h00);
    settle;
    chk(16'(irq_o), 16'h0000);
  endtask

  // serial mode, second longer, upper size bit set so start code is ignored
  task automatic t_scan2;
    cfg(8'h80, 8'h26, 8'h00, 8'h01, 3'h3, 3'h6);
    wait_pad(n);
    chk(16'(scan_pad_o), 16'h0007);
    wait_pad(n);
    chk(16'(n), 16'(2 * STEP_CYCLES));
  endtask

  // row/column mode in interrupt scan: second on-time must not stretch the group,
  // and the scanner parks after a round until the status bit is cleared
  task automatic t_scan3;
    cfg(8'h00, 8'h04, 8'h00, 8'h03, 3'h2, 3'h6);
    wait_pad(n);
    wait_pad(n);
    chk(16'(n), 16'(STEP_CYCLES));
    n = 0;
    while (irq_o !== 1'b1 && n < 20000)
    begin
      @(posedge sys_clk_i);
      #1;
      n++;
    end
    chk(16'(irq_o), 16'h0001);
    chk(16'(scan_active_o), 16'h0000);
    chk(16'(scan_pad_o), 16'h0006);
    rc(0, ADDR_IRQ_STATUS, 8'h01);
    wr(0, ADDR_IRQ_STATUS, 8'h00);
    rc(0, ADDR_IRQ_STATUS, 8'h00);
    chk(16'(scan_active_o), 16'h0001);
    rc(0, ADDR_IRQ_FLAG, 8'h40);
    wr(0, ADDR_SCAN_RUN, 8'h00);
  endtask

  // main sequence: quiet inputs, ten-cycle reset, then the scenarios
  initial
  begin
    sys_clk_i             = 1'b0;
    rst_n_i               = 1'b0;
    sfr_addr_i            = 8'h00;
    sfr_wr_i              = 1'b0;
    sfr_rd_i              = 1'b0;
    sfr_wdata_i           = 8'h00;
    sec_addr_i            = 8'h00;
    sec_wr_i              = 1'b0;
    sec_rd_i              = 1'b0;
    sec_wdata_i           = 8'h00;
    lamp_on_i             = 1'b0;
    lamp_segment_select_i = 1'b0;
    repeat (10) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    settle;
    chk(16'(scan_active_o), 16'h0000);
    t_regs;
    t_drive;
    t_irq;
    t_scan1;
    t_scan2;
    t_scan3;
    summarize;
  end
endmodule
